// *** rtl/ppo_defs.svh ***
`ifndef PPO_DEFS_SVH
`define PPO_DEFS_SVH

// Port geometry
`define PPO_NPINS          4
`define PPO_PIN_ZERO       0
`define PPO_PIN_ONE        1
`define PPO_PIN_TWO        2
`define PPO_PIN_THREE      3

// Register indexes; byte address is four times the index
`define PPO_IDX_INPUT      2'h0
`define PPO_IDX_DIRECTION  2'h1
`define PPO_IDX_OUTDATA    2'h2
`define PPO_IDX_PULLUP     2'h3
`define PPO_ADDR_LOW_ZERO  2'h0
`define PPO_ADDR_TOP_ZERO  28'h0000000

// Reset values and read padding
`define PPO_PINS_RESET     4'h0
`define PPO_RDATA_PAD      28'h0000000
`define PPO_RDATA_RESET    32'h00000000

// Fixed override levels of the pin map
`define PPO_TIE_OFF        1'b0
`define PPO_TIE_ON         1'b1

`endif

// *** rtl/ppo_pkg.sv ***
package ppo_pkg;

	// One bit per port pin
	typedef logic [3:0] ppo_pins_type;

	// Register selector, binary codes match the register indexes
	typedef enum logic [1:0] {
		PPO_REG_INPUT     = 2'b00,
		PPO_REG_DIRECTION = 2'b01,
		PPO_REG_OUTDATA   = 2'b10,
		PPO_REG_PULLUP    = 2'b11
	} ppo_reg_type;

endpackage

// *** rtl/ppo_if.sv ***
interface ppo_if;

	// Overrides driven by the alternate-function end, one bit per pin
	ppo_pkg::ppo_pins_type pullup_override_en;
	ppo_pkg::ppo_pins_type pullup_override_val;
	ppo_pkg::ppo_pins_type dir_override_en;
	ppo_pkg::ppo_pins_type dir_override_val;
	ppo_pkg::ppo_pins_type outval_override_en;
	ppo_pkg::ppo_pins_type outval_override_val;
	ppo_pkg::ppo_pins_type toggle_override_en;
	ppo_pkg::ppo_pins_type inen_override_en;
	ppo_pkg::ppo_pins_type inen_override_val;
	// Unsynchronized pin level towards the alternate functions
	ppo_pkg::ppo_pins_type alt_input_tap;

	modport port_end (
		input  pullup_override_en,
		input  pullup_override_val,
		input  dir_override_en,
		input  dir_override_val,
		input  outval_override_en,
		input  outval_override_val,
		input  toggle_override_en,
		input  inen_override_en,
		input  inen_override_val,
		output alt_input_tap
	);

	modport alt_end (
		output pullup_override_en,
		output pullup_override_val,
		output dir_override_en,
		output dir_override_val,
		output outval_override_en,
		output outval_override_val,
		output toggle_override_en,
		output inen_override_en,
		output inen_override_val,
		input  alt_input_tap
	);

endinterface

// *** rtl/ppo_port.sv ***
`include "ppo_defs.svh"

// Notes on behaviour
// - Pull-up from override value, else register bit
// - Pull-up override ignores the pull-up register bit
// - Driver enable from override value, else direction
// - Direction override ignores the direction bit
// - Driven level from value override, else outdata
// - Toggle override inverts the output data bit
// - Input enable from override, else run/sleep
// - Input override ignores run or sleep state
// - Alternate input tapped before the synchronizer
// - Consumers synchronize the tap unless clocking
// - Strobes shared per port, overrides per pin
// - Alternate modules drive their own override pairs
// - Pin zero direction must be output for compare A
// - Pin one direction must be output for compare B
// - Pin zero: comparator, compare A, pinchange, data
// - Pin one: comparator, clocks, capture, compare B
// - Pin two: clock out, irq, pinchange, count
// - Pin three: pinchange source and reset input
// - Comparator pins: input, pull-up off
// - Direction bit one is output, zero input
// - Output data bit sets driven level
// - Pull-up bit one switches pull-up on
// - Writing one to input bit toggles outdata
module ppo_port (
	// Clock and reset
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	// APB slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [31:0]           paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	// Controller state
	input  wire logic                  sleep_req,
	// Pads
	input  wire ppo_pkg::ppo_pins_type pad_in,
	output ppo_pkg::ppo_pins_type      pad_out,
	output ppo_pkg::ppo_pins_type      pad_oe,
	output ppo_pkg::ppo_pins_type      pad_pullup,
	// Alternate-function side
	ppo_if.port_end                    alt
);

	ppo_pkg::ppo_pins_type pin_pullup_bit;
	ppo_pkg::ppo_pins_type pin_direction_bit;
	ppo_pkg::ppo_pins_type pin_outdata_bit;
	ppo_pkg::ppo_pins_type pin_input_bit;
	ppo_pkg::ppo_pins_type sync_meta;
	ppo_pkg::ppo_pins_type inen;
	ppo_pkg::ppo_pins_type next_pad_out;
	ppo_pkg::ppo_pins_type next_pad_oe;
	ppo_pkg::ppo_pins_type next_pad_pullup;
	logic                  setup_phase;
	logic                  wr_strobe;
	logic                  addr_ok;
	ppo_pkg::ppo_reg_type  reg_sel;

	// Word-aligned decode of the four register indexes
	function automatic logic ppo_addr_valid(input logic [31:0] addr);
		ppo_addr_valid = (addr[31:4] == `PPO_ADDR_TOP_ZERO) && (addr[1:0] == `PPO_ADDR_LOW_ZERO);
	endfunction

	function automatic ppo_pkg::ppo_reg_type ppo_addr_reg(input logic [31:0] addr);
		ppo_addr_reg = ppo_pkg::ppo_reg_type'(addr[3:2]);
	endfunction

	// Only the low pin field of a written word reaches the registers
	function automatic ppo_pkg::ppo_pins_type ppo_wdata_pins(input logic [31:0] data);
		ppo_wdata_pins = data[`PPO_NPINS-1:0];
	endfunction

	// Bus phase decode; one write strobe serves all pins of the port
	assign setup_phase = psel & ~penable;
	assign addr_ok     = ppo_addr_valid(paddr);
	assign reg_sel     = ppo_addr_reg(paddr);
	assign wr_strobe   = psel & penable & pready & pwrite & addr_ok;

	// Zero-wait slave: ready and error come up in the access phase
	// No wait states: every register answers in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup_phase;
			pslverr <= setup_phase & ~addr_ok;
		end
	end

	// Read data captured in the setup cycle so it stands as a flop output
	// Writes and refused places read back as zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= `PPO_RDATA_RESET;
		end else if (setup_phase) begin
			if (!addr_ok || pwrite) begin
				prdata <= `PPO_RDATA_RESET;
			end else begin
				case (reg_sel)
					ppo_pkg::PPO_REG_INPUT:     prdata <= {`PPO_RDATA_PAD, pin_input_bit};
					ppo_pkg::PPO_REG_DIRECTION: prdata <= {`PPO_RDATA_PAD, pin_direction_bit};
					ppo_pkg::PPO_REG_OUTDATA:   prdata <= {`PPO_RDATA_PAD, pin_outdata_bit};
					ppo_pkg::PPO_REG_PULLUP:    prdata <= {`PPO_RDATA_PAD, pin_pullup_bit};
					default:                    prdata <= `PPO_RDATA_RESET;
				endcase
			end
		end
	end

	// Direction register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_direction_bit <= `PPO_PINS_RESET;
		end else if (wr_strobe && reg_sel == ppo_pkg::PPO_REG_DIRECTION) begin
			pin_direction_bit <= ppo_wdata_pins(pwdata);
		end
	end

	// Pull-up register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_pullup_bit <= `PPO_PINS_RESET;
		end else if (wr_strobe && reg_sel == ppo_pkg::PPO_REG_PULLUP) begin
			pin_pullup_bit <= ppo_wdata_pins(pwdata);
		end
	end

	// Output data register; ones written to the input register flip it
	// whatever the direction, so software can toggle without read-modify-write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_outdata_bit <= `PPO_PINS_RESET;
		end else if (wr_strobe && reg_sel == ppo_pkg::PPO_REG_OUTDATA) begin
			pin_outdata_bit <= ppo_wdata_pins(pwdata);
		end else if (wr_strobe && reg_sel == ppo_pkg::PPO_REG_INPUT) begin
			pin_outdata_bit <= pin_outdata_bit ^ ppo_wdata_pins(pwdata);
		end
	end

	// Digital input enable: override wins, else off while the controller sleeps
	always_comb begin
		for (int i = 0; i < `PPO_NPINS; i++) begin
			if (alt.inen_override_en[i]) begin
				inen[i] = alt.inen_override_val[i];
			end else begin
				inen[i] = ~sleep_req;
			end
		end
	end

	// Clamped schmitt output goes straight to the alternate functions;
	// they see it unsynchronized and must resynchronize it themselves
	assign alt.alt_input_tap = pad_in & inen;

	// Two-flop synchronizer; the clamp acts after the first stage
	// Only the second stage reads the first, so metastability stays contained
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_meta     <= `PPO_PINS_RESET;
			pin_input_bit <= `PPO_PINS_RESET;
		end else begin
			sync_meta     <= pad_in;
			pin_input_bit <= sync_meta & inen;
		end
	end

	// Per-pin override muxes for driver, level and pull-up
	always_comb begin
		for (int i = 0; i < `PPO_NPINS; i++) begin
			if (alt.dir_override_en[i]) begin
				next_pad_oe[i] = alt.dir_override_val[i];
			end else begin
				next_pad_oe[i] = pin_direction_bit[i];
			end
			if (alt.outval_override_en[i]) begin
				next_pad_out[i] = alt.outval_override_val[i];
			end else begin
				next_pad_out[i] = pin_outdata_bit[i] ^ alt.toggle_override_en[i];
			end
			if (alt.pullup_override_en[i]) begin
				next_pad_pullup[i] = alt.pullup_override_val[i];
			end else begin
				next_pad_pullup[i] = pin_pullup_bit[i];
			end
		end
	end

	// Pad controls registered: one cycle of latency, but no override glitch
	// reaches the pad, and reset tri-states every pin with pull-ups off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pad_oe     <= `PPO_PINS_RESET;
			pad_out    <= `PPO_PINS_RESET;
			pad_pullup <= `PPO_PINS_RESET;
		end else begin
			pad_oe     <= next_pad_oe;
			pad_out    <= next_pad_out;
			pad_pullup <= next_pad_pullup;
		end
	end

endmodule

// *** rtl/ppo_alt.sv ***
`include "ppo_defs.svh"

module ppo_alt (
	// Clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// Configuration from fuses and clock system
	input  wire logic             clock_out_sel,
	input  wire logic             reset_pin_off,
	input  wire logic             ext_clock_sel,
	input  wire logic             pwr_down,
	// Timer compare outputs
	input  wire logic             timer_compare_a_out,
	input  wire logic             timer_compare_a_en,
	input  wire logic             timer_compare_b_out,
	input  wire logic             timer_compare_b_en,
	// Interrupt and analog enables
	input  wire ppo_pkg::ppo_pins_type pinchange_mask,
	input  wire logic             pinchange_group_en,
	input  wire logic             ext_irq_zero_en,
	input  wire ppo_pkg::ppo_pins_type adc_digital_off,
	// Synchronized inputs to the peripherals
	output logic                  pinchange_src_zero,
	output logic                  pinchange_src_one,
	output logic                  pinchange_src_two,
	output logic                  pinchange_src_three,
	output logic                  ext_irq_zero_src,
	output logic                  timer_ext_count_in,
	output logic                  timer_capture_in,
	output logic                  prog_serial_data,
	output logic                  prog_serial_clock,
	// Raw clock tap
	output logic                  ext_clock_in,
	// Pin side
	ppo_if.alt_end                pins
);

	ppo_pkg::ppo_pins_type tap_meta;
	ppo_pkg::ppo_pins_type tap_sync;
	ppo_pkg::ppo_pins_type pc_on;
	logic                  sys_clock_out;

	assign pc_on = pinchange_mask & {`PPO_NPINS{pinchange_group_en}};

	// Clock-out level: pclk halved so it can leave from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sys_clock_out <= `PPO_TIE_OFF;
		end else begin
			sys_clock_out <= ~sys_clock_out;
		end
	end

	// Override pairs for every pin; functions a pin lacks are tied off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pins.pullup_override_en  <= `PPO_PINS_RESET;
			pins.pullup_override_val <= `PPO_PINS_RESET;
			pins.dir_override_en     <= `PPO_PINS_RESET;
			pins.dir_override_val    <= `PPO_PINS_RESET;
			pins.outval_override_en  <= `PPO_PINS_RESET;
			pins.outval_override_val <= `PPO_PINS_RESET;
			pins.toggle_override_en  <= `PPO_PINS_RESET;
			pins.inen_override_en    <= `PPO_PINS_RESET;
			pins.inen_override_val   <= `PPO_PINS_RESET;
		end else begin
			// Compare outputs only set the level; direction stays with software
			pins.pullup_override_en  <= {reset_pin_off, clock_out_sel, ext_clock_sel, `PPO_TIE_OFF};
			pins.pullup_override_val <= {`PPO_TIE_ON, `PPO_TIE_OFF, `PPO_TIE_OFF, `PPO_TIE_OFF};
			pins.dir_override_en     <= {reset_pin_off, clock_out_sel, ext_clock_sel, `PPO_TIE_OFF};
			pins.dir_override_val    <= {`PPO_TIE_OFF, `PPO_TIE_ON, `PPO_TIE_OFF, `PPO_TIE_OFF};
			pins.outval_override_en  <= {`PPO_TIE_OFF, clock_out_sel, ext_clock_sel | timer_compare_b_en,
				timer_compare_a_en};
			// Pin one passes the compare B level; under the external clock its driver is off anyway
			pins.outval_override_val <= {`PPO_TIE_OFF, sys_clock_out, timer_compare_b_out,
				timer_compare_a_out};
			pins.toggle_override_en  <= {`PPO_NPINS{`PPO_TIE_OFF}};
			pins.inen_override_en    <= {reset_pin_off | pc_on[`PPO_PIN_THREE] | adc_digital_off[`PPO_PIN_THREE],
				pc_on[`PPO_PIN_TWO] | adc_digital_off[`PPO_PIN_TWO] | ext_irq_zero_en,
				ext_clock_sel | pc_on[`PPO_PIN_ONE] | adc_digital_off[`PPO_PIN_ONE],
				pc_on[`PPO_PIN_ZERO] | adc_digital_off[`PPO_PIN_ZERO]};
			pins.inen_override_val   <= {reset_pin_off & pc_on[`PPO_PIN_THREE],
				pc_on[`PPO_PIN_TWO] | ext_irq_zero_en,
				(ext_clock_sel & pwr_down) | (ext_clock_sel & pc_on[`PPO_PIN_ONE]),
				pc_on[`PPO_PIN_ZERO]};
		end
	end

	// Own two-flop synchronizer for every consumer of the raw tap except the clock input
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tap_meta <= `PPO_PINS_RESET;
			tap_sync <= `PPO_PINS_RESET;
		end else begin
			tap_meta <= pins.alt_input_tap;
			tap_sync <= tap_meta;
		end
	end

	// Synchronized levels fanned out to their peripherals
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pinchange_src_zero  <= `PPO_TIE_OFF;
			pinchange_src_one   <= `PPO_TIE_OFF;
			pinchange_src_two   <= `PPO_TIE_OFF;
			pinchange_src_three <= `PPO_TIE_OFF;
			ext_irq_zero_src    <= `PPO_TIE_OFF;
			timer_ext_count_in  <= `PPO_TIE_OFF;
			timer_capture_in    <= `PPO_TIE_OFF;
			prog_serial_data    <= `PPO_TIE_OFF;
			prog_serial_clock   <= `PPO_TIE_OFF;
		end else begin
			pinchange_src_zero  <= tap_sync[`PPO_PIN_ZERO];
			prog_serial_data    <= tap_sync[`PPO_PIN_ZERO];
			pinchange_src_one   <= tap_sync[`PPO_PIN_ONE];
			timer_capture_in    <= tap_sync[`PPO_PIN_ONE];
			prog_serial_clock   <= tap_sync[`PPO_PIN_ONE];
			pinchange_src_two   <= tap_sync[`PPO_PIN_TWO];
			ext_irq_zero_src    <= tap_sync[`PPO_PIN_TWO];
			timer_ext_count_in  <= tap_sync[`PPO_PIN_TWO];
			pinchange_src_three <= tap_sync[`PPO_PIN_THREE];
		end
	end

	// A clock source must not be resampled, so it leaves unsynchronized
	assign ext_clock_in = pins.alt_input_tap[`PPO_PIN_ONE];

endmodule

// *** verif/ppo_assertions.sv ***
// Watches the override link and the pads it steers
module ppo_assertions (
	// Clock, reset and controller state
	input wire logic                  pclk,
	input wire logic                  presetn,
	input wire logic                  sleep_req,
	// Pads
	input wire ppo_pkg::ppo_pins_type pad_in,
	input wire ppo_pkg::ppo_pins_type pad_out,
	input wire ppo_pkg::ppo_pins_type pad_oe,
	input wire ppo_pkg::ppo_pins_type pad_pullup,
	// Override link
	input wire ppo_pkg::ppo_pins_type pullup_override_en,
	input wire ppo_pkg::ppo_pins_type pullup_override_val,
	input wire ppo_pkg::ppo_pins_type dir_override_en,
	input wire ppo_pkg::ppo_pins_type dir_override_val,
	input wire ppo_pkg::ppo_pins_type outval_override_en,
	input wire ppo_pkg::ppo_pins_type outval_override_val,
	input wire ppo_pkg::ppo_pins_type toggle_override_en,
	input wire ppo_pkg::ppo_pins_type inen_override_en,
	input wire ppo_pkg::ppo_pins_type inen_override_val,
	input wire ppo_pkg::ppo_pins_type alt_input_tap
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Pads are registered, so they answer the overrides of the previous edge
	pullup_ovr_a: assert property (
		((pad_pullup ^ $past(pullup_override_val)) & $past(pullup_override_en)) == 4'h0)
		else $error("pull-up ignores its override");
	dir_ovr_a: assert property (
		((pad_oe ^ $past(dir_override_val)) & $past(dir_override_en)) == 4'h0)
		else $error("driver enable ignores its override");
	outval_ovr_a: assert property (
		((pad_out ^ $past(outval_override_val)) & $past(outval_override_en)) == 4'h0)
		else $error("driven level ignores its override");
	// The tap is combinational, so it is compared in the same cycle
	inen_ovr_a: assert property (
		((alt_input_tap ^ (pad_in & inen_override_val)) & inen_override_en) == 4'h0)
		else $error("input enable ignores its override");
	inen_run_a: assert property (
		((alt_input_tap ^ (pad_in & {4{!sleep_req}})) & ~inen_override_en) == 4'h0)
		else $error("tap does not follow run or sleep");
	no_toggle_a: assert property (toggle_override_en == 4'h0)
		else $error("toggle override raised on a pin without it");
	pin_zero_a: assert property ((pullup_override_en[0] | dir_override_en[0]) == 1'b0)
		else $error("pin zero pull-up or direction overridden");
	pin_one_a: assert property (
		dir_override_en[1] |-> !dir_override_val[1] && pullup_override_en[1] && !pullup_override_val[1])
		else $error("pin one clock input map wrong");
	pin_two_a: assert property (
		dir_override_en[2] |-> dir_override_val[2] && outval_override_en[2] && !pullup_override_val[2])
		else $error("pin two clock output map wrong");
	clock_out_a: assert property (
		outval_override_en[2] && $past(outval_override_en[2])
		|-> outval_override_val[2] != $past(outval_override_val[2]))
		else $error("clock output does not toggle");
	pin_three_a: assert property (
		pullup_override_en[3] |-> pullup_override_val[3] && dir_override_en[3] && !dir_override_val[3])
		else $error("pin three reset map wrong");
endmodule

// *** verif/port_pin_override_mux_tb.sv ***
module port_pin_override_mux_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic                  pclk = 1'b0;
	logic                  presetn = 1'b0;
	logic                  psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sleep_req = 1'b0;
	logic [31:0]           paddr = 32'h0, pwdata = 32'h0, prdata, rd_data;
	logic                  pready, pslverr, rd_err, lvl, pc0, pc2, ext_ck_in;
	logic                  pc1, pc3, irq0, t0_in, cap_in, pdat, pck;
	ppo_pkg::ppo_pins_type pad_in = 4'h0, pc_mask = 4'h0, adc_off = 4'h0, pad_out, pad_oe, pad_pullup;
	logic                  ck_out = 1'b0, rst_off = 1'b0, ext_ck = 1'b0, pwr_dn = 1'b0, pc_grp = 1'b0;
	logic                  cmp_a = 1'b0, cmp_a_en = 1'b0, cmp_b = 1'b0, cmp_b_en = 1'b0, irq0_en = 1'b0;
	int                    miscompares = 0, total_checks = 0, cycles = 0;

	// Free-running 40 MHz clock
	always #12.5 pclk = ~pclk;

	ppo_if ppo_if_inst ();
	ppo_port ppo_port_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sleep_req(sleep_req),
		.pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup), .alt(ppo_if_inst.port_end));
	// Every configuration and enable input is driven by the sequence
	ppo_alt ppo_alt_inst (.pclk(pclk), .presetn(presetn), .clock_out_sel(ck_out), .reset_pin_off(rst_off),
		.ext_clock_sel(ext_ck), .pwr_down(pwr_dn), .timer_compare_a_out(cmp_a), .timer_compare_a_en(cmp_a_en),
		.timer_compare_b_out(cmp_b), .timer_compare_b_en(cmp_b_en), .pinchange_mask(pc_mask),
		.pinchange_group_en(pc_grp), .ext_irq_zero_en(irq0_en), .adc_digital_off(adc_off), .pinchange_src_zero(pc0),
		.pinchange_src_one(pc1), .pinchange_src_two(pc2), .pinchange_src_three(pc3), .ext_irq_zero_src(irq0),
		.timer_ext_count_in(t0_in), .timer_capture_in(cap_in), .prog_serial_data(pdat), .prog_serial_clock(pck),
		.ext_clock_in(ext_ck_in), .pins(ppo_if_inst.alt_end));
	ppo_assertions ppo_assertions_inst (.pclk(pclk), .presetn(presetn), .sleep_req(sleep_req), .pad_in(pad_in),
		.pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup),
		.pullup_override_en(ppo_if_inst.pullup_override_en), .pullup_override_val(ppo_if_inst.pullup_override_val),
		.dir_override_en(ppo_if_inst.dir_override_en), .dir_override_val(ppo_if_inst.dir_override_val),
		.outval_override_en(ppo_if_inst.outval_override_en), .outval_override_val(ppo_if_inst.outval_override_val),
		.toggle_override_en(ppo_if_inst.toggle_override_en), .inen_override_en(ppo_if_inst.inen_override_en),
		.inen_override_val(ppo_if_inst.inen_override_val), .alt_input_tap(ppo_if_inst.alt_input_tap));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One APB transfer; the request stands until pready is seen high
	task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] wdat);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= wdat;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the hang guard ends a wait that never gets its answer
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd_data = prdata;
		rd_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [31:0] addr, input logic [31:0] data, input logic err);
		apb(1'b1, addr, data);
		check({31'h0, rd_err}, {31'h0, err});
	endtask

	task automatic rd(input logic [31:0] addr, input logic [31:0] exp, input logic err);
		apb(1'b0, addr, 32'h0);
		check({31'h0, rd_err}, {31'h0, err});
		check(rd_data, exp);
	endtask

	// Let overrides pass their two register stages, then look between edges
	task automatic settle();
		repeat (4) @(posedge pclk);
		@(negedge pclk);
	endtask

	task automatic pads(input logic [3:0] oe, input logic [3:0] pu);
		settle();
		check({28'h0, pad_oe}, {28'h0, oe});
		check({28'h0, pad_pullup}, {28'h0, pu});
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Hang guard, far above the fewer than two hundred cycles the sequence needs
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 4000) begin
			miscompares++;
			stop_test();
		end
	end

	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		rd(32'h4, 32'h0, 1'b0);
		rd(32'hC, 32'h0, 1'b0);
		rd(32'h8, 32'h0, 1'b0);
		$display("test reset values done");
		// Plain register control, back to back writes
		wr(32'h4, 32'h5, 1'b0);
		wr(32'h8, 32'h3, 1'b0);
		wr(32'hC, 32'hA, 1'b0);
		pads(4'h5, 4'hA);
		check({28'h0, pad_out}, 32'h3);
		wr(32'h0, 32'h6, 1'b0);
		rd(32'h8, 32'h5, 1'b0);
		// Out-of-map and misaligned places are refused and write nothing
		wr(32'h10, 32'hF, 1'b1);
		wr(32'h6, 32'hF, 1'b1);
		rd(32'h6, 32'h0, 1'b1);
		rd(32'h4, 32'h5, 1'b0);
		$display("test register control done");
		@(posedge pclk);
		pad_in <= 4'h9;
		settle();
		rd(32'h0, 32'h9, 1'b0);
		@(posedge pclk);
		sleep_req <= 1'b1;
		settle();
		check({28'h0, ppo_if_inst.alt_input_tap}, 32'h0);
		rd(32'h0, 32'h0, 1'b0);
		@(posedge pclk);
		sleep_req <= 1'b0;
		$display("test input and sleep done");
		// Clock output takes pin two whatever its registers say
		wr(32'h4, 32'h0, 1'b0);
		wr(32'hC, 32'hF, 1'b0);
		@(posedge pclk);
		ck_out <= 1'b1;
		pads(4'h4, 4'hB);
		lvl = pad_out[2];
		@(negedge pclk);
		check({31'h0, pad_out[2]}, {31'h0, ~lvl});
		@(posedge pclk);
		ck_out <= 1'b0;
		// Reset function keeps pin three an input with pull-up
		wr(32'h4, 32'h8, 1'b0);
		wr(32'hC, 32'h0, 1'b0);
		@(posedge pclk);
		rst_off <= 1'b1;
		pads(4'h0, 4'h8);
		check({28'h0, ppo_if_inst.alt_input_tap}, 32'h1);
		@(posedge pclk);
		rst_off <= 1'b0;
		$display("test pins two and three done");
		// External clock on pin one blocks driver, pull-up and input while awake
		wr(32'h4, 32'h2, 1'b0);
		wr(32'hC, 32'h2, 1'b0);
		@(posedge pclk);
		ext_ck <= 1'b1;
		cmp_b <= 1'b1;
		pad_in <= 4'hF;
		pads(4'h0, 4'h0);
		check({31'h0, pad_out[1]}, 32'h1);
		check({28'h0, ppo_if_inst.alt_input_tap}, 32'hD);
		@(posedge pclk);
		pwr_dn <= 1'b1;
		settle();
		check({28'h0, ppo_if_inst.alt_input_tap}, 32'hF);
		check({31'h0, ext_ck_in}, 32'h1);
		@(posedge pclk);
		ext_ck <= 1'b0;
		pwr_dn <= 1'b0;
		// Compare A drives pin zero only while its enable is up
		wr(32'h4, 32'h1, 1'b0);
		wr(32'h8, 32'h0, 1'b0);
		@(posedge pclk);
		cmp_a <= 1'b1;
		cmp_a_en <= 1'b1;
		pads(4'h1, 4'h2);
		check({31'h0, pad_out[0]}, 32'h1);
		@(posedge pclk);
		cmp_a_en <= 1'b0;
		settle();
		check({31'h0, pad_out[0]}, 32'h0);
		// Compare B drives pin one once software has made it an output
		wr(32'h4, 32'h2, 1'b0);
		@(posedge pclk);
		cmp_b_en <= 1'b1;
		pads(4'h2, 4'h2);
		check({31'h0, pad_out[1]}, 32'h1);
		@(posedge pclk);
		cmp_b <= 1'b0;
		settle();
		check({31'h0, pad_out[1]}, 32'h0);
		@(posedge pclk);
		cmp_b_en <= 1'b0;
		$display("test pins zero and one done");
		// Pin change keeps inputs alive in sleep; pin one and three stay clamped
		@(posedge pclk);
		sleep_req <= 1'b1;
		pc_mask <= 4'hF;
		pc_grp <= 1'b1;
		settle();
		check({28'h0, ppo_if_inst.alt_input_tap}, 32'h5);
		settle();
		check({23'h0, pc3, pc2, pc1, pc0, irq0, t0_in, cap_in, pdat, pck}, 32'hBA);
		$display("test pin change done");
		// Comparator pin zero: input, pull-up off, digital input clamped
		wr(32'h4, 32'h0, 1'b0);
		wr(32'hC, 32'h0, 1'b0);
		@(posedge pclk);
		pc_mask <= 4'h0;
		pc_grp <= 1'b0;
		irq0_en <= 1'b1;
		adc_off <= 4'h1;
		pads(4'h0, 4'h0);
		check({28'h0, ppo_if_inst.alt_input_tap}, 32'h4);
		@(posedge pclk);
		sleep_req <= 1'b0;
		settle();
		check({28'h0, ppo_if_inst.alt_input_tap}, 32'hE);
		$display("test interrupt and analog clamp done");
		stop_test();
	end
endmodule
